// File: core/event_counter_pair.sv
// Pair of 8-bit event counters, cascadable to 16 bits, with gate and flags
`timescale 1ns/1ps

// Summary of operation
// - Upper release bit 0 holds upper counter at zero; 1 lets it count.
// - Lower release bit 0 holds lower counter at zero; 1 lets it count.
// - Overflow flags clear only by writing 0; writing 1 never sets them.
// - Upper counter is read-only; clocked by pin, divided clock, or lower overflow.
// - Lower counter is read-only; clocked by its pin or divided clock.
// - Software clears either counter to zero regardless of clock source.
// - Split bit 0 cascades both counters into one 16-bit counter.
// - In 16-bit mode lower select picks divide 2, 4, 8 or lower pin.
// - Each event pin counts edges per its own 2-bit edge select.
// - PWM gate disabled: count only while gate pin is high.
// - One gate signal gates both counters together.
// - After reset: cascaded, lower select zero, falling edges on lower pin.
// - 16-bit count wrapping from all ones sets upper overflow flag.
// - Any overflow sets counter interrupt request; enable bit forwards it.
// - Split bit 1 runs two independent 8-bit counters.
// - In split mode upper select picks divide 2, 4, 8 or upper pin.
// - Split mode upper wrap from all ones sets upper overflow flag.
// - Split mode lower wrap from all ones sets lower overflow flag.
// - Gate pin interrupt uses vector 6, addresses 000C and 000D.
// - Gate event sets gate request flag; enable bit forwards it.
// - Clock select codes: 00 pin, 01 div2, 10 div4, 11 div8.
// - PWM gate enable 0 selects gate pin; 1 selects PWM gate.
// - Count enable bit 0 freezes counter and ignores clocks.
// - Gate interrupt senses rising, falling or both edges by select field; the code senses none while PWM gate enable is 1.
module event_counter_pair
   import event_counter_pkg::*;
(
   // Clock, reset, enable
   input  wire logic        i_clk_sys,
   input  wire logic        i_reset,
   input  wire logic        i_clk_en,
   // Register port
   input  wire logic [2:0]  i_reg_addr,
   input  wire logic [7:0]  i_reg_wdata,
   input  wire logic        i_reg_write,
   input  wire logic        i_reg_read,
   output logic      [7:0]  o_reg_rdata,
   // External pins and internal PWM gate
   input  wire logic        i_upper_event_pin,
   input  wire logic        i_lower_event_pin,
   input  wire logic        i_count_gate_pin,
   input  wire logic        i_pwm_gate_signal,
   // Interrupt requests to the processor
   output logic             o_counter_irq,
   output logic             o_gate_irq,
   output logic      [3:0]  o_gate_irq_vector
);

   typedef struct packed {
      pin_sync_t  sync;
      logic [2:0] presc;
      logic [7:0] upper_counter;
      logic [7:0] lower_counter;
      logic [7:0] control_status;
      logic [7:0] clock_select;
      logic [7:0] edge_gate;
      logic [1:0] irq_request;
      logic [1:0] irq_enable;
      logic [7:0] rdata;
      logic       counter_irq;
      logic       gate_irq;
      logic [3:0] vector;
   } state_t;

   state_t s_q;
   state_t s_d;

   // Counting model
   // Each counter advances on one tick per
   // clock edge at most; a tick is a seen
   // pin edge or a prescaler wrap point.

   // Both counters share one gate, so the
   // upper and lower bytes cannot be held
   // apart by the gate alone; the count
   // enable bits do that per counter.

   // Cascade
   // With split low the upper byte takes
   // the lower wrap as its only tick, in
   // the same edge as the lower rollover.
   // The lower flag stays quiet then; only
   // the full 16-bit rollover raises the
   // upper flag.

   // Split
   // With split high each byte has its own
   // source and its own flag; both flags
   // feed the single counter request.

   // Release bits
   // A release bit at zero holds its byte
   // at zero every cycle. Software clears a
   // counter by dropping its release bit,
   // whatever the source; the byte starts
   // again from zero once it is raised.

   // Event pins
   // Pins are asynchronous, so two flops
   // sit in front of any logic. A third
   // stage keeps the previous level for
   // edge detection; stages two and three
   // are the ones read by the detector.
   // Limitation: a pulse shorter than
   // about one clock may be missed.

   // After reset the chains hold zero; a
   // pin idling high shows one rising edge
   // as the chain fills. Falling is the
   // reset edge code, so nothing counts.

   // Divided sources
   // The prescaler runs freely and is not
   // restarted by a mode change; the first
   // divided tick after a change may come
   // early. Trade-off: one counter of three
   // bits serves all three dividers.

   // Gate
   // The PWM gate comes from logic on this
   // clock and needs no synchroniser. The
   // gate pin does, and its edges also feed
   // the gate request per its edge code while the PWM gate is not selected.
   // A gate edge cutting a tick may lose
   // one count, as with any such gating.

   // Flags and requests
   // Hardware sets win over a software
   // clear in the same cycle, so no event
   // is lost while software clears a flag.
   // Writing one to a flag keeps it.

   // Register port
   // Read data stands one cycle after the
   // strobe and is zero otherwise, so the
   // port can be or-ed onto a shared bus.
   // Count registers ignore writes.

   // Clock enable
   // Low enable freezes every flop, the
   // synchronisers and prescaler included,
   // so counts resume exactly where they
   // stopped.


   // Edge detection on a synchronised level against its previous value
   function automatic logic edge_hit(input logic [1:0] sel, input logic cur, input logic prev);
      logic rise;
      logic fall;
      rise = cur & ~prev;
      fall = ~cur & prev;
      case (sel)
         EDGE_FALLING: edge_hit = fall;
         EDGE_RISING:  edge_hit = rise;
         default:      edge_hit = rise | fall;
      endcase
   endfunction : edge_hit

   // Source tick from clock select code; divided ticks from the prescaler
   function automatic logic src_tick(input logic [1:0] sel, input logic pin_edge, input logic [2:0] presc);
      case (sel)
         SRC_EVENT_PIN: src_tick = pin_edge;
         SRC_DIV2:      src_tick = presc[0];
         SRC_DIV4:      src_tick = &presc[1:0];
         SRC_DIV8:      src_tick = &presc;
         default:       src_tick = 1'b0;
      endcase
   endfunction : src_tick

   logic       split;
   logic       gate;
   logic       upper_edge;
   logic       lower_edge;
   logic       gate_edge;
   logic       lower_inc;
   logic       upper_inc;
   logic       lower_wrap;
   logic       upper_wrap;
   logic       set_upper_ovf;
   logic       set_lower_ovf;
   logic       wr_ccs;
   logic [7:0] ccs_w;

   // Next-state logic
   always_comb
   begin
      s_d = s_q;

      // Two-flop synchronisers, third stage is the previous level
      s_d.sync.upper_pin = {s_q.sync.upper_pin[1:0], i_upper_event_pin};
      s_d.sync.lower_pin = {s_q.sync.lower_pin[1:0], i_lower_event_pin};
      s_d.sync.gate_pin  = {s_q.sync.gate_pin[1:0], i_count_gate_pin};

      // Free-running prescaler for the divided sources
      s_d.presc = s_q.presc + PRESC_ONE;

      split = s_q.control_status[CCS_CHANNEL_SPLIT];

      // Only synchronised stages feed edge logic
      upper_edge = edge_hit(s_q.edge_gate[EGS_UPPER_EDGE_LSB +: 2],
                            s_q.sync.upper_pin[1], s_q.sync.upper_pin[2]);
      lower_edge = edge_hit(s_q.edge_gate[EGS_LOWER_EDGE_LSB +: 2],
                            s_q.sync.lower_pin[1], s_q.sync.lower_pin[2]);

      // Single gate for both counters; PWM gate is same-clock, unsynchronised
      gate = s_q.edge_gate[EGS_PWM_GATE_EN] ? i_pwm_gate_signal
                                             : s_q.sync.gate_pin[1];
      gate_edge = s_q.edge_gate[EGS_PWM_GATE_EN] ? 1'b0
                : edge_hit(s_q.edge_gate[EGS_GATE_EDGE_LSB +: 2],
                           s_q.sync.gate_pin[1], s_q.sync.gate_pin[2]);

      // Lower counter increment
      lower_inc = gate && s_q.control_status[CCS_LOWER_CUE] && s_q.control_status[CCS_LOWER_REL]
                  && src_tick(s_q.clock_select[CKS_LOWER_LSB +: 2], lower_edge, s_q.presc);
      lower_wrap = lower_inc && (s_q.lower_counter == BYTE_ONES);

      // Upper counter: own source in split mode, lower carry when cascaded
      if (split)
      begin
         upper_inc = gate && src_tick(s_q.clock_select[CKS_UPPER_LSB +: 2], upper_edge, s_q.presc);
      end
      else
      begin
         upper_inc = lower_wrap;
      end
      upper_inc = upper_inc && s_q.control_status[CCS_UPPER_CUE]
                  && s_q.control_status[CCS_UPPER_REL];
      upper_wrap = upper_inc && (s_q.upper_counter == BYTE_ONES);

      // Counting; release bit low holds the counter at zero
      if (!s_q.control_status[CCS_LOWER_REL])
      begin
         s_d.lower_counter = BYTE_ZERO;
      end
      else if (lower_inc)
      begin
         s_d.lower_counter = s_q.lower_counter + BYTE_ONE;
      end
      if (!s_q.control_status[CCS_UPPER_REL])
      begin
         s_d.upper_counter = BYTE_ZERO;
      end
      else if (upper_inc)
      begin
         s_d.upper_counter = s_q.upper_counter + BYTE_ONE;
      end

      // Overflow events; lower flag only reports in split mode
      set_upper_ovf = upper_wrap;
      set_lower_ovf = lower_wrap && split;

      // Register writes
      wr_ccs = i_reg_write && (i_reg_addr == ADDR_CONTROL_STATUS);
      ccs_w  = i_reg_wdata;
      if (wr_ccs)
      begin
         s_d.control_status = {s_q.control_status[CCS_UPPER_OVF] & ccs_w[CCS_UPPER_OVF],
                               s_q.control_status[CCS_LOWER_OVF] & ccs_w[CCS_LOWER_OVF],
                               ccs_w[CCS_RESERVED:0]};
      end
      if (i_reg_write && (i_reg_addr == ADDR_CLOCK_SELECT))
      begin
         s_d.clock_select = i_reg_wdata;
      end
      if (i_reg_write && (i_reg_addr == ADDR_EDGE_GATE))
      begin
         s_d.edge_gate = i_reg_wdata;
      end
      if (i_reg_write && (i_reg_addr == ADDR_IRQ_REQUEST))
      begin
         s_d.irq_request = s_q.irq_request & i_reg_wdata[1:0];  // Write 0 clears
      end
      if (i_reg_write && (i_reg_addr == ADDR_IRQ_ENABLE))
      begin
         s_d.irq_enable = i_reg_wdata[1:0];
      end

      // Hardware sets win over a same-cycle software clear
      if (set_upper_ovf)
      begin
         s_d.control_status[CCS_UPPER_OVF] = 1'b1;
      end
      if (set_lower_ovf)
      begin
         s_d.control_status[CCS_LOWER_OVF] = 1'b1;
      end
      if (set_upper_ovf || set_lower_ovf)
      begin
         s_d.irq_request[IRQ_COUNTER_BIT] = 1'b1;
      end
      if (gate_edge)
      begin
         s_d.irq_request[IRQ_GATE_BIT] = 1'b1;
      end

      // Requests forwarded only when enabled
      s_d.counter_irq = s_d.irq_request[IRQ_COUNTER_BIT] & s_d.irq_enable[IRQ_COUNTER_BIT];
      s_d.gate_irq    = s_d.irq_request[IRQ_GATE_BIT] & s_d.irq_enable[IRQ_GATE_BIT];
      s_d.vector      = GATE_IRQ_VECTOR;

      // Read data one cycle after the strobe, zero otherwise
      s_d.rdata = BYTE_ZERO;
      if (i_reg_read)
      begin
         case (i_reg_addr)
            ADDR_CONTROL_STATUS: s_d.rdata = s_q.control_status;
            ADDR_UPPER_COUNT:    s_d.rdata = s_q.upper_counter;
            ADDR_LOWER_COUNT:    s_d.rdata = s_q.lower_counter;
            ADDR_CLOCK_SELECT:   s_d.rdata = s_q.clock_select;
            ADDR_EDGE_GATE:      s_d.rdata = s_q.edge_gate;
            ADDR_IRQ_REQUEST:    s_d.rdata = {6'h00, s_q.irq_request};
            ADDR_IRQ_ENABLE:     s_d.rdata = {6'h00, s_q.irq_enable};
            default:             s_d.rdata = BYTE_ZERO;
         endcase
      end
   end


   // Reset
   // Reset is synchronous and clears the
   // whole state at once; all controls at
   // zero give the documented start-up:
   // cascaded, pin source, falling edges,
   // counters held in reset, no requests.

   // The vector output reads zero during
   // reset and the constant from the first
   // enabled edge after it.

   // State register; all controls zero gives cascaded, falling edge, pin source
   always_ff @(posedge i_clk_sys)
   begin
      if (i_reset)
      begin
         s_q <= '0;
      end
      else if (i_clk_en)
      begin
         s_q <= s_d;
      end
   end

   // Outputs straight from flops
   assign o_reg_rdata       = s_q.rdata;
   assign o_counter_irq     = s_q.counter_irq;
   assign o_gate_irq        = s_q.gate_irq;
   assign o_gate_irq_vector = s_q.vector;

endmodule : event_counter_pair

// File: core/event_counter_pkg.sv
// Constants for the event counter pair: register map, fields, encodings
package event_counter_pkg;

   // Register word indices on the plain register port
   localparam logic [2:0] ADDR_CONTROL_STATUS = 3'h0;
   localparam logic [2:0] ADDR_UPPER_COUNT    = 3'h1;
   localparam logic [2:0] ADDR_LOWER_COUNT    = 3'h2;
   localparam logic [2:0] ADDR_CLOCK_SELECT   = 3'h3;
   localparam logic [2:0] ADDR_EDGE_GATE      = 3'h4;
   localparam logic [2:0] ADDR_IRQ_REQUEST    = 3'h5;
   localparam logic [2:0] ADDR_IRQ_ENABLE     = 3'h6;

   // counter_control_status fields
   localparam int CCS_UPPER_OVF     = 7;
   localparam int CCS_LOWER_OVF     = 6;
   localparam int CCS_RESERVED      = 5;
   localparam int CCS_CHANNEL_SPLIT = 4;
   localparam int CCS_UPPER_CUE     = 3;
   localparam int CCS_LOWER_CUE     = 2;
   localparam int CCS_UPPER_REL     = 1;
   localparam int CCS_LOWER_REL     = 0;

   // counter_clock_select_register fields
   localparam int CKS_UPPER_LSB = 6;
   localparam int CKS_LOWER_LSB = 4;

   // edge_and_gate_select_register fields
   localparam int EGS_UPPER_EDGE_LSB = 6;
   localparam int EGS_LOWER_EDGE_LSB = 4;
   localparam int EGS_GATE_EDGE_LSB  = 2;
   localparam int EGS_PWM_GATE_EN    = 1;

   // Interrupt request / enable fields
   localparam int IRQ_COUNTER_BIT = 0;
   localparam int IRQ_GATE_BIT    = 1;

   // Clock source codes
   localparam logic [1:0] SRC_EVENT_PIN = 2'h0;
   localparam logic [1:0] SRC_DIV2      = 2'h1;
   localparam logic [1:0] SRC_DIV4      = 2'h2;
   localparam logic [1:0] SRC_DIV8      = 2'h3;

   // Edge select codes; falling is the reset value
   localparam logic [1:0] EDGE_FALLING = 2'h0;
   localparam logic [1:0] EDGE_RISING  = 2'h1;
   localparam logic [1:0] EDGE_BOTH    = 2'h2;

   // Gate interrupt vector number and addresses
   localparam logic [3:0]  GATE_IRQ_VECTOR    = 4'h6;
   localparam logic [15:0] GATE_IRQ_VEC_ADDR0 = 16'h000C;
   localparam logic [15:0] GATE_IRQ_VEC_ADDR1 = 16'h000D;

   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BYTE_ONES = 8'hFF;
   localparam logic [7:0] BYTE_ONE  = 8'h01;
   localparam logic [2:0] PRESC_ONE = 3'h1;

   // Sync chain stages: 0,1 synchronise, 2 holds the previous level
   typedef struct packed {
      logic [2:0] upper_pin;
      logic [2:0] lower_pin;
      logic [2:0] gate_pin;
   } pin_sync_t;

endpackage : event_counter_pkg

// File: test/event_counter_pair_checker.sv
// Port-level assertions for the event counter pair
`timescale 1ns/1ps
module event_counter_pair_checker
   import event_counter_pkg::*;
(
   // Clock, reset, register port, requests
   input wire logic       i_clk_sys,
   input wire logic       i_reset,
   input wire logic       i_clk_en,
   input wire logic [2:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic       i_reg_write,
   input wire logic       i_reg_read,
   input wire logic [7:0] o_reg_rdata,
   input wire logic       o_counter_irq,
   input wire logic       o_gate_irq,
   input wire logic [3:0] o_gate_irq_vector
);
   logic [7:0] ccs_q;
   logic [7:0] cks_q;
   logic [7:0] egs_q;
   logic [7:0] ien_q;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);
   // Shadows of plain writes; hardware-set flags are masked where read
   always_ff @(posedge i_clk_sys)
      if (i_reset)
         {ccs_q, cks_q, egs_q, ien_q} <= '0;
      else if (i_clk_en && i_reg_write)
         case (i_reg_addr)
            ADDR_CONTROL_STATUS: ccs_q <= i_reg_wdata;
            ADDR_CLOCK_SELECT:   cks_q <= i_reg_wdata;
            ADDR_EDGE_GATE:      egs_q <= i_reg_wdata;
            ADDR_IRQ_ENABLE:     ien_q <= i_reg_wdata;
            default:             ;
         endcase
   a_rdata_idle: assert property (i_clk_en && !i_reg_read |=> o_reg_rdata == 8'h00)
      else $error("read data not zero outside a read answer");
   a_unmapped_reads_zero: assert property (i_reg_read && i_reg_addr == 3'h7 |=> o_reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_clock_select_echo: assert property (i_reg_read && i_reg_addr == ADDR_CLOCK_SELECT |=> o_reg_rdata == $past(cks_q))
      else $error("clock select readback wrong");
   a_edge_select_echo: assert property (i_reg_read && i_reg_addr == ADDR_EDGE_GATE |=> o_reg_rdata == $past(egs_q))
      else $error("edge select readback wrong");
   a_control_bits_echo: assert property (i_reg_read && i_reg_addr == ADDR_CONTROL_STATUS
      |=> o_reg_rdata[5:0] == $past(ccs_q[5:0]))
      else $error("control readback wrong");
   a_upper_held_zero: assert property (i_reg_read && i_reg_addr == ADDR_UPPER_COUNT && !ccs_q[CCS_UPPER_REL]
      && !$past(ccs_q[CCS_UPPER_REL]) |=> o_reg_rdata == 8'h00)
      else $error("upper counter not held in reset");
   a_lower_held_zero: assert property (i_reg_read && i_reg_addr == ADDR_LOWER_COUNT && !ccs_q[CCS_LOWER_REL]
      && !$past(ccs_q[CCS_LOWER_REL]) |=> o_reg_rdata == 8'h00)
      else $error("lower counter not held in reset");
   a_gate_irq_masked: assert property (!ien_q[IRQ_GATE_BIT] && !$past(ien_q[IRQ_GATE_BIT]) |-> !o_gate_irq)
      else $error("gate request passed while disabled");
   a_counter_irq_masked: assert property (!ien_q[IRQ_COUNTER_BIT] && !$past(ien_q[IRQ_COUNTER_BIT]) |-> !o_counter_irq)
      else $error("counter request passed while disabled");
   a_vector_six: assert property ($past(i_clk_en) && !$past(i_reset) |-> o_gate_irq_vector == GATE_IRQ_VECTOR)
      else $error("gate vector wrong");
endmodule : event_counter_pair_checker
bind event_counter_pair event_counter_pair_checker event_counter_pair_checker_inst (.i_clk_sys(i_clk_sys),
   .i_reset(i_reset), .i_clk_en(i_clk_en), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
   .i_reg_write(i_reg_write), .i_reg_read(i_reg_read), .o_reg_rdata(o_reg_rdata), .o_counter_irq(o_counter_irq),
   .o_gate_irq(o_gate_irq), .o_gate_irq_vector(o_gate_irq_vector));

// File: test/event_counter_pair_tb_top.sv
// Self-checking bench for the event counter pair
`timescale 1ns/1ps
module event_counter_pair_tb_top;
   import event_counter_pkg::*;
   logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, pwm = 1'b0, gate = 1'b0, start = 1'b0;
   logic [2:0] addr = 3'h0, half = 3'h3;
   logic [7:0] wdata = 8'h00, rdata;
   logic [9:0] n_up = 10'h000, n_lo = 10'h000;
   logic       up_pin, lo_pin, gate_pin, busy, cnt_irq, gate_irq, rd_seen = 1'b0;
   logic [3:0] vec;
   logic       cke = 1'b1;
   logic [7:0] exp_q[$];
   int         n_mismatch = 0, checks_done = 0, seed = 32'h90E78BA2, r;
   always #2 clk = ~clk;
   event_counter_pair event_counter_pair_inst (.i_clk_sys(clk), .i_reset(rst), .i_clk_en(cke), .i_reg_addr(addr),
      .i_reg_wdata(wdata), .i_reg_write(wr), .i_reg_read(rd), .o_reg_rdata(rdata), .i_upper_event_pin(up_pin),
      .i_lower_event_pin(lo_pin), .i_count_gate_pin(gate_pin), .i_pwm_gate_signal(pwm), .o_counter_irq(cnt_irq),
      .o_gate_irq(gate_irq), .o_gate_irq_vector(vec));
   event_source_model event_source_model_inst (.i_clk_sys(clk), .i_start(start), .i_n_upper(n_up), .i_n_lower(n_lo),
      .i_half(half), .i_gate_high(gate), .o_upper_event_pin(up_pin), .o_lower_event_pin(lo_pin),
      .o_count_gate_pin(gate_pin), .o_busy(busy));
   task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: expected %h got %h", $time, e, g);
      end
   endtask : cmp_byte
   task automatic cmp_bit(input logic e, input logic g);
      cmp_byte({7'h00, e}, {7'h00, g});
   endtask : cmp_bit
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      {addr, wdata, wr} <= {a, d, 1'b1};
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   // Expected data is queued now and compared when the answer stands
   task automatic rd_reg(input logic [2:0] a, input logic [7:0] e);
      @(posedge clk);
      {addr, rd} <= {a, 1'b1};
      exp_q.push_back(e);
      @(posedge clk);
      rd <= 1'b0;
   endtask : rd_reg
   // Pulse widths vary so the synchroniser sees slow and quick events
   task automatic pulses(input logic [9:0] u, input logic [9:0] l);
      @(posedge clk);
      {n_up, n_lo, start, half} <= {u, l, 1'b1, 3'(3 + ($random(seed) & 3))};
      @(posedge clk);
      start <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 20000 && busy === 1'b1; i++)
         @(posedge clk);
      repeat (6) @(posedge clk);
   endtask : pulses
   always @(posedge clk)
   begin
      if (rd_seen)
         cmp_byte(exp_q.pop_front(), rdata);
      rd_seen <= rd;
   end
   task automatic conclude();
      $display("Counts: %0d checks, %0d mismatches", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : conclude
   initial
   begin
      repeat (40000) @(posedge clk);
      n_mismatch++;
      $display("Watchdog expired at %0t", $time);
      conclude();
   end
   initial
   begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      for (int a = 0; a < 8; a++)
         rd_reg(3'(a), 8'h00);
      $display("Test reset_values done");
      for (int i = 0; i < 4; i++)
      begin
         r = $random(seed);
         wr_reg(ADDR_CLOCK_SELECT, r[7:0]);
         rd_reg(ADDR_CLOCK_SELECT, r[7:0]);
         wr_reg(ADDR_EDGE_GATE, r[15:8]);
         rd_reg(ADDR_EDGE_GATE, r[15:8]);
         wr_reg(ADDR_CONTROL_STATUS, r[23:16] | 8'hC0);
         rd_reg(ADDR_CONTROL_STATUS, r[23:16] & 8'h3F);
         wr_reg(ADDR_UPPER_COUNT, r[31:24]);
         rd_reg(ADDR_UPPER_COUNT, 8'h00);
      end
      wr_reg(ADDR_CLOCK_SELECT, 8'h00);
      wr_reg(ADDR_EDGE_GATE, 8'h00);
      $display("Test register_access done");
      // Cascaded: lower carry reaches the upper byte
      gate <= 1'b1;
      wr_reg(ADDR_CONTROL_STATUS, 8'h0F);
      pulses(10'h000, 10'h102);
      rd_reg(ADDR_LOWER_COUNT, 8'h02);
      rd_reg(ADDR_UPPER_COUNT, 8'h01);
      rd_reg(ADDR_CONTROL_STATUS, 8'h0F);
      gate <= 1'b0;
      pulses(10'h000, 10'h003);
      rd_reg(ADDR_LOWER_COUNT, 8'h02);
      wr_reg(ADDR_EDGE_GATE, 8'h02);
      pwm <= 1'b1;
      pulses(10'h000, 10'h003);
      rd_reg(ADDR_LOWER_COUNT, 8'h05);
      wr_reg(ADDR_CONTROL_STATUS, 8'h00);
      rd_reg(ADDR_UPPER_COUNT, 8'h00);
      rd_reg(ADDR_LOWER_COUNT, 8'h00);
      pwm <= 1'b0;
      wr_reg(ADDR_EDGE_GATE, 8'h00);
      $display("Test cascade done");
      // Split: upper counts rising edges and wraps, lower counts both
      gate <= 1'b1;
      wr_reg(ADDR_IRQ_REQUEST, 8'h00);
      wr_reg(ADDR_IRQ_ENABLE, 8'h01);
      wr_reg(ADDR_EDGE_GATE, 8'h60);
      wr_reg(ADDR_CONTROL_STATUS, 8'h1F);
      pulses(10'h100, 10'h002);
      rd_reg(ADDR_UPPER_COUNT, 8'h00);
      rd_reg(ADDR_LOWER_COUNT, 8'h04);
      rd_reg(ADDR_CONTROL_STATUS, 8'h9F);
      rd_reg(ADDR_IRQ_REQUEST, 8'h01);
      cmp_bit(1'b1, cnt_irq);
      wr_reg(ADDR_CONTROL_STATUS, 8'hDF);
      rd_reg(ADDR_CONTROL_STATUS, 8'h9F);
      wr_reg(ADDR_CONTROL_STATUS, 8'h1F);
      rd_reg(ADDR_CONTROL_STATUS, 8'h1F);
      wr_reg(ADDR_IRQ_REQUEST, 8'h00);
      repeat (3) @(posedge clk);
      cmp_bit(1'b0, cnt_irq);
      $display("Test split done");
      // Gate request on rising edge only
      wr_reg(ADDR_EDGE_GATE, 8'h04);
      wr_reg(ADDR_IRQ_ENABLE, 8'h02);
      gate <= 1'b0;
      repeat (8) @(posedge clk);
      rd_reg(ADDR_IRQ_REQUEST, 8'h00);
      gate <= 1'b1;
      repeat (8) @(posedge clk);
      rd_reg(ADDR_IRQ_REQUEST, 8'h02);
      cmp_bit(1'b1, gate_irq);
      cmp_byte({4'h0, GATE_IRQ_VECTOR}, {4'h0, vec});
      repeat (3) @(posedge clk);
      $display("Test gate_irq done");
      // Divided sources over 64 enabled cycles; enable low freezes all
      wr_reg(ADDR_CONTROL_STATUS, 8'h10);
      wr_reg(ADDR_CLOCK_SELECT, 8'h70);
      wr_reg(ADDR_CONTROL_STATUS, 8'h1F);
      repeat (30) @(posedge clk);
      cke <= 1'b0;
      repeat (20) @(posedge clk);
      cke <= 1'b1;
      repeat (32) @(posedge clk);
      wr_reg(ADDR_CONTROL_STATUS, 8'h13);
      rd_reg(ADDR_UPPER_COUNT, 8'h20);
      rd_reg(ADDR_LOWER_COUNT, 8'h08);
      repeat (16) @(posedge clk);
      rd_reg(ADDR_UPPER_COUNT, 8'h20);
      $display("Test divided_sources done");
      conclude();
   end
endmodule : event_counter_pair_tb_top

// File: test/event_source_model.sv
// Event pins and gate pin driven from outside the counter pair
`timescale 1ns/1ps
module event_source_model
(
   // Clock and commands
   input  wire logic       i_clk_sys,
   input  wire logic       i_start,
   input  wire logic [9:0] i_n_upper,
   input  wire logic [9:0] i_n_lower,
   input  wire logic [2:0] i_half,
   input  wire logic       i_gate_high,
   // Pins
   output logic            o_upper_event_pin,
   output logic            o_lower_event_pin,
   output logic            o_count_gate_pin,
   output logic            o_busy
);
   // Pins idle high: each pulse gives one falling then one rising edge
   initial
   begin
      {o_upper_event_pin, o_lower_event_pin, o_busy} = 3'h6;
      forever
      begin
         @(posedge i_clk_sys);
         if (i_start)
         begin
            o_busy <= 1'b1;
            for (int k = 0; k < i_n_upper + i_n_lower; k++)
            begin
               if (k < i_n_upper)
                  o_upper_event_pin <= 1'b0;
               else
                  o_lower_event_pin <= 1'b0;
               repeat (i_half) @(posedge i_clk_sys);
               {o_upper_event_pin, o_lower_event_pin} <= 2'h3;
               repeat (i_half) @(posedge i_clk_sys);
            end
            o_busy <= 1'b0;
         end
      end
   end
   // Gate held high to count, low to suspend
   always @(posedge i_clk_sys)
      o_count_gate_pin <= i_gate_high;
endmodule : event_source_model
